/* File: core/dpm_io_monitor.sv */
`timescale 1ns/1ps
// Packs input, output and status words; din_in arrives already synchronised, the other inputs do not
module dpm_io_monitor (
  input  wire logic [6:0]  din_in,
  input  wire logic [2:0]  dout_in,
  input  wire logic [6:0]  in_polarity_in,
  input  wire logic [2:0]  out_polarity_in,
  input  wire logic [6:0]  run_wire_mask_in,
  input  wire logic        run_fwd_in,
  input  wire logic        run_rev_in,
  input  wire logic        ready_in,
  input  wire logic        error_in,
  input  wire logic        warning_in,
  output logic      [15:0] di_adj_out,
  output logic      [15:0] di_raw_out,
  output logic      [15:0] do_adj_out,
  output logic      [15:0] do_raw_out,
  output logic      [15:0] status_out
);

  // ------------------------------------------------------------
  // Input word, polarity skipped on run-control inputs
  // ------------------------------------------------------------
  wire [6:0] di_flip = in_polarity_in & ~run_wire_mask_in;
  assign di_adj_out = {9'h000, din_in ^ di_flip};
  assign di_raw_out = {9'h000, din_in};

  // Output word: relay, output 1, output 2
  assign do_adj_out = {13'h0000, dout_in ^ out_polarity_in};
  assign do_raw_out = {13'h0000, dout_in};

  // Drive status word
  assign status_out = {10'h000, warning_in, run_fwd_in | run_rev_in,
                       error_in, ready_in, run_rev_in, run_fwd_in};

endmodule

/* File: core/dpm_param_bank.sv */
`timescale 1ns/1ps
module dpm_param_bank #(
  parameter logic [15:0] FW_VERSION = 16'h0100, // Arbitrary value
  parameter int unsigned RESET_WINDOW = dpm_pkg::RESET_WINDOW_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        keypad_src_in,
  output logic      [15:0] rdata_out,
  input  wire logic [6:0]  din_pin_in,
  input  wire logic [2:0]  dout_state_in,
  input  wire logic        run_fwd_in,
  input  wire logic        run_rev_in,
  input  wire logic        drive_ready_in,
  input  wire logic        drive_error_in,
  input  wire logic        ext_warning_in,
  input  wire logic [15:0] out_freq_in,
  input  wire logic [15:0] torque_in,
  input  wire logic [15:0] overload_in,
  input  wire logic        copy_req_in,
  output logic             copy_allow_out,
  output logic             keypad_locked_out,
  output logic             lock_flash_out,
  output logic [2:0]       bad_count_out,
  output logic             factory_reset_out,
  output logic             overload_warning_out,
  output logic             torque_mode_out,
  output logic [15:0]      speed_format_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] din_meta;
  logic [6:0] din_sync;

  // Pins pass two flops before any logic sees them
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      din_meta <= 7'h00;
      din_sync <= 7'h00;
    end else begin
      din_meta <= din_pin_in;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam int IRQ_W = dpm_pkg::IRQ_BITS;

  logic [15:0] display_sel;
  logic [15:0] coef_gain;
  logic [15:0] pw_entry;
  logic [15:0] pw_secret;
  logic        pw_set;
  logic        pw_unlocked;
  logic [15:0] ctrl_mode;
  logic [15:0] speed_format;
  logic [6:0]  in_polarity;
  logic [2:0]  out_polarity;
  logic [15:0] run_wire_sel;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [2:0]  bad_count;
  logic        factory_armed;
  logic [31:0] window_cnt;
  logic        flash_tgl;
  logic [23:0] flash_cnt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire protected_now = pw_set & ~pw_unlocked;
  wire locked        = (bad_count == dpm_pkg::MAX_BAD_TRIES);
  // Keypad writes other than interrupt status clears are dropped after lockout; the remote port still works
  wire wr_ok         = wr_in & ~(keypad_src_in & locked);
  wire wr_gen        = wr_ok & ~protected_now;
  wire wr_entry      = wr_ok & (addr_in == dpm_pkg::ADDR_PW_ENTRY);
  wire wr_setting    = wr_gen & (addr_in == dpm_pkg::ADDR_PW_SETTING);
  wire entry_is_rst  = wdata_in == dpm_pkg::PW_RESET_CODE;
  wire entry_good    = pw_set & (wdata_in == pw_secret) & ~entry_is_rst;
  wire pw_good       = wr_entry & entry_good;
  wire pw_bad        = wr_entry & pw_set & ~entry_good & ~entry_is_rst
                       & ~locked;
  wire window_live   = window_cnt != 32'h0000_0000;
  wire factory       = wr_entry & entry_is_rst & factory_armed
                       & window_live;
  wire rst_first     = wr_entry & entry_is_rst & ~factory;
  wire wr_int_status = wr_in & (addr_in == dpm_pkg::ADDR_INT_STATUS);

  // ----------------------------------------------------------------
  // Monitor words
  // ----------------------------------------------------------------
  wire [15:0] di_adj;
  wire [15:0] di_raw;
  wire [15:0] do_adj;
  wire [15:0] do_raw;
  wire [15:0] drive_status;
  wire [6:0]  run_mask = (run_wire_sel != 16'h0000) ? 7'h07 : 7'h00;

  dpm_io_monitor u_mon (
    .din_in           (din_sync),
    .dout_in          (dout_state_in),
    .in_polarity_in   (in_polarity),
    .out_polarity_in  (out_polarity),
    .run_wire_mask_in (run_mask),
    .run_fwd_in       (run_fwd_in),
    .run_rev_in       (run_rev_in),
    .ready_in         (drive_ready_in),
    .error_in         (drive_error_in),
    .warning_in       (ext_warning_in | overload_warning_out),
    .di_adj_out       (di_adj),
    .di_raw_out       (di_raw),
    .do_adj_out       (do_adj),
    .do_raw_out       (do_raw),
    .status_out       (drive_status)
  );

  // Gain is in hundredths, so the product is rescaled by 100
  wire [31:0] gain_prod   = out_freq_in * coef_gain;
  wire [31:0] gain_scaled = gain_prod / 32'd100;
  wire        overload    = overload_in >= dpm_pkg::OVERLOAD_LIMIT;
  assign overload_warning_out =
    (display_sel == dpm_pkg::SEL_OVERLOAD) & overload;

  // Selected display word; torque arrives already in percent of rated
  logic [15:0] display_val;
  always_comb begin
    unique case (display_sel)
      dpm_pkg::SEL_DI_ADJ:    display_val = di_adj;
      dpm_pkg::SEL_DI_RAW:    display_val = di_raw;
      dpm_pkg::SEL_DO_ADJ:    display_val = do_adj;
      dpm_pkg::SEL_DO_RAW:    display_val = do_raw;
      dpm_pkg::SEL_TORQUE:    display_val = torque_in;
      dpm_pkg::SEL_OVERLOAD:  display_val = overload_in;
      dpm_pkg::SEL_GAIN_FREQ: display_val = gain_scaled[15:0];
      dpm_pkg::SEL_STATUS:    display_val = drive_status;
      dpm_pkg::SEL_OUT_FREQ:  display_val = out_freq_in;
      default:                display_val = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    unique case (addr_in)
      dpm_pkg::ADDR_DISPLAY_SEL:  rd_mux = display_sel;
      dpm_pkg::ADDR_COEF_GAIN:    rd_mux = coef_gain;
      dpm_pkg::ADDR_FW_VERSION:   rd_mux = FW_VERSION;
      dpm_pkg::ADDR_PW_ENTRY:     rd_mux = pw_entry;
      dpm_pkg::ADDR_CTRL_MODE:    rd_mux = ctrl_mode;
      dpm_pkg::ADDR_SPEED_FORMAT: rd_mux = speed_format;
      dpm_pkg::ADDR_IN_POLARITY:  rd_mux = {9'h000, in_polarity};
      dpm_pkg::ADDR_OUT_POLARITY: rd_mux = {13'h0000, out_polarity};
      dpm_pkg::ADDR_RUN_WIRE_SEL: rd_mux = run_wire_sel;
      dpm_pkg::ADDR_DISPLAY_VAL:  rd_mux = display_val;
      dpm_pkg::ADDR_INT_STATUS:   rd_mux = {12'h000, irq_status};
      dpm_pkg::ADDR_INT_MASK:     rd_mux = {12'h000, irq_mask};
      dpm_pkg::ADDR_PW_STATUS:    rd_mux = {13'h0000, bad_count};
      // Reads zero once the right password has lifted protection
      dpm_pkg::ADDR_PW_SETTING:   rd_mux = {15'h0000, protected_now};
      default:                    rd_mux = 16'h0000;
    endcase
  end

  // Protection hides everything but the setting register
  wire [15:0] rd_visible =
    (protected_now && addr_in != dpm_pkg::ADDR_PW_SETTING) ?
    16'h0000 : rd_mux;

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? rd_visible : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Plain parameters
  // ----------------------------------------------------------------
  wire wr_p = wr_gen & ~factory;
  wire [15:0] gain_clip = (wdata_in > dpm_pkg::COEF_GAIN_MAX) ?
                          dpm_pkg::COEF_GAIN_MAX : wdata_in;
  wire mode_legal = (wdata_in == dpm_pkg::MODE_SPEED) |
                    (wdata_in == dpm_pkg::MODE_TORQUE);

  // Factory restore puts every setting back to its reset value
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      display_sel  <= dpm_pkg::DISPLAY_SEL_RESET;
      coef_gain    <= dpm_pkg::COEF_GAIN_RESET;
      ctrl_mode    <= dpm_pkg::MODE_SPEED;
      speed_format <= 16'h0000;
      in_polarity  <= 7'h00;
      out_polarity <= 3'h0;
      run_wire_sel <= 16'h0000;
      irq_mask     <= '0;
    end else if (factory) begin
      display_sel  <= dpm_pkg::DISPLAY_SEL_RESET;
      coef_gain    <= dpm_pkg::COEF_GAIN_RESET;
      ctrl_mode    <= dpm_pkg::MODE_SPEED;
      speed_format <= 16'h0000;
      in_polarity  <= 7'h00;
      out_polarity <= 3'h0;
      run_wire_sel <= 16'h0000;
      irq_mask     <= '0;
    end else if (wr_p) begin
      unique case (addr_in)
        dpm_pkg::ADDR_DISPLAY_SEL:  display_sel <= wdata_in;
        dpm_pkg::ADDR_COEF_GAIN:    coef_gain <= gain_clip;
        dpm_pkg::ADDR_CTRL_MODE: begin
          if (mode_legal) ctrl_mode <= wdata_in;
        end
        dpm_pkg::ADDR_SPEED_FORMAT: speed_format <= wdata_in;
        dpm_pkg::ADDR_IN_POLARITY:  in_polarity <= wdata_in[6:0];
        dpm_pkg::ADDR_OUT_POLARITY: out_polarity <= wdata_in[2:0];
        dpm_pkg::ADDR_RUN_WIRE_SEL: run_wire_sel <= wdata_in;
        dpm_pkg::ADDR_INT_MASK:     irq_mask <= wdata_in[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Torque mode leaves the speed format unused
  assign torque_mode_out  = ctrl_mode == dpm_pkg::MODE_TORQUE;
  assign speed_format_out = torque_mode_out ? 16'h0000 : speed_format;

  // ----------------------------------------------------------------
  // Password handling
  // ----------------------------------------------------------------
  // Password is volatile: reset clears the secret and leaves protection off
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pw_entry    <= 16'h0000;
      pw_secret   <= 16'h0000;
      pw_set      <= 1'b0;
      pw_unlocked <= 1'b0;
      bad_count   <= 3'h0;
    end else if (factory) begin
      pw_entry    <= 16'h0000;
      pw_secret   <= 16'h0000;
      pw_set      <= 1'b0;
      pw_unlocked <= 1'b0;
      bad_count   <= 3'h0;
    end else begin
      if (wr_entry) pw_entry <= wdata_in;
      if (pw_good) begin
        pw_unlocked <= 1'b1;
        bad_count   <= 3'h0;
      end else if (pw_bad) begin
        bad_count <= bad_count + 3'h1;
      end
      if (wr_setting) begin
        pw_secret   <= wdata_in;
        pw_set      <= wdata_in != 16'h0000;
        pw_unlocked <= 1'b0;
      end
    end
  end

  // 9999 arms a window; a second 9999 inside it restores defaults
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      factory_armed <= 1'b0;
      window_cnt    <= 32'h0000_0000;
    end else if (rst_first) begin
      factory_armed <= 1'b1;
      window_cnt    <= RESET_WINDOW[31:0];
    end else if (factory || !window_live) begin
      factory_armed <= 1'b0;
      window_cnt    <= 32'h0000_0000;
    end else begin
      window_cnt    <= window_cnt - 32'h0000_0001;
    end
  end

  // Lock indication blinks at a slow rate
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flash_cnt <= 24'h000000;
      flash_tgl <= 1'b0;
    end else begin
      flash_cnt <= flash_cnt + 24'h000001;
      if (flash_cnt == 24'hFFFFFF) flash_tgl <= ~flash_tgl;
    end
  end

  assign keypad_locked_out = locked;
  assign lock_flash_out    = locked & flash_tgl;
  assign bad_count_out     = bad_count;
  assign factory_reset_out = factory;
  // Copy never carries the secret; it only runs unprotected
  assign copy_allow_out    = copy_req_in & ~protected_now;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_ev;
  logic             ovl_q;
  always_comb begin
    irq_ev = '0;
    irq_ev[dpm_pkg::IRQ_BAD_PW]   = pw_bad;
    irq_ev[dpm_pkg::IRQ_LOCKOUT]  = pw_bad & (bad_count ==
                                    dpm_pkg::MAX_BAD_TRIES - 3'h1);
    irq_ev[dpm_pkg::IRQ_OVERLOAD] = overload_warning_out & ~ovl_q;
    irq_ev[dpm_pkg::IRQ_FACTORY]  = factory;
  end

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status <= '0;
      ovl_q      <= 1'b0;
    end else begin
      ovl_q      <= overload_warning_out;
      irq_status <= (irq_status &
                    ~(wr_int_status ? wdata_in[IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

endmodule

/* File: core/dpm_pkg.sv */
package dpm_pkg;

  // ----------------------------------------------------------------
  // Register indices on the parameter port
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DISPLAY_SEL  = 16'h0004;
  localparam logic [15:0] ADDR_COEF_GAIN    = 16'h0005;
  localparam logic [15:0] ADDR_FW_VERSION   = 16'h0006;
  localparam logic [15:0] ADDR_PW_ENTRY     = 16'h0007;
  localparam logic [15:0] ADDR_CTRL_MODE    = 16'h000A;
  localparam logic [15:0] ADDR_SPEED_FORMAT = 16'h000B;
  localparam logic [15:0] ADDR_IN_POLARITY  = 16'h0100;
  localparam logic [15:0] ADDR_OUT_POLARITY = 16'h0101;
  localparam logic [15:0] ADDR_RUN_WIRE_SEL = 16'h0102;
  localparam logic [15:0] ADDR_DISPLAY_VAL  = 16'h0103;
  localparam logic [15:0] ADDR_INT_STATUS   = 16'h0104;
  localparam logic [15:0] ADDR_INT_MASK     = 16'h0105;
  localparam logic [15:0] ADDR_PW_STATUS    = 16'h0106;
  localparam logic [15:0] ADDR_PW_SETTING   = 16'h8000;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] COEF_GAIN_RESET   = 16'h0064; // 1.00
  localparam logic [15:0] COEF_GAIN_MAX     = 16'h3E80; // 160.00
  localparam logic [15:0] DISPLAY_SEL_RESET = 16'h0003;
  localparam logic [15:0] PW_RESET_CODE     = 16'h270F; // 9999
  localparam logic [15:0] PW_SET_ACTIVE     = 16'h0001;
  localparam logic [15:0] MODE_SPEED        = 16'h0000;
  localparam logic [15:0] MODE_TORQUE       = 16'h0002;
  localparam logic [15:0] OVERLOAD_LIMIT    = 16'h2710; // 100.00 %
  localparam logic [2:0]  MAX_BAD_TRIES     = 3'h4;
  localparam logic [15:0] TORQUE_FULL_SCALE = 16'h0064; // 100 %

  // Display selector codes
  localparam logic [15:0] SEL_OUT_FREQ   = 16'h0002;
  localparam logic [15:0] SEL_TORQUE     = 16'h0008;
  localparam logic [15:0] SEL_DI_ADJ     = 16'h0010;
  localparam logic [15:0] SEL_DO_ADJ     = 16'h0011;
  localparam logic [15:0] SEL_DI_RAW     = 16'h0013;
  localparam logic [15:0] SEL_DO_RAW     = 16'h0014;
  localparam logic [15:0] SEL_OVERLOAD   = 16'h0019;
  localparam logic [15:0] SEL_GAIN_FREQ  = 16'h001F;
  localparam logic [15:0] SEL_STATUS     = 16'h0026;

  // Interrupt status bits
  localparam int IRQ_BAD_PW   = 0;
  localparam int IRQ_LOCKOUT  = 1;
  localparam int IRQ_OVERLOAD = 2;
  localparam int IRQ_FACTORY  = 3;
  localparam int IRQ_BITS     = 4;

  // Time for the second 9999 confirmation
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned RESET_WINDOW_S   = 10;
  localparam int unsigned RESET_WINDOW_CYC = CLK_HZ * RESET_WINDOW_S;

endpackage

/* File: sim/dpm_chk.sv */
`timescale 1ns/1ps
// Watches the parameter bank ports; fires on any broken relation
module dpm_chk (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic [15:0] addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        copy_req_in,
  input wire logic [15:0] overload_in,
  input wire logic [15:0] rdata_out,
  input wire logic        copy_allow_out,
  input wire logic        keypad_locked_out,
  input wire logic        lock_flash_out,
  input wire logic [2:0]  bad_count_out,
  input wire logic        factory_reset_out,
  input wire logic        overload_warning_out,
  input wire logic        torque_mode_out,
  input wire logic [15:0] speed_format_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_pulse;
    factory_reset_out ##1 !factory_reset_out;
  endsequence
  sequence s_no_read;
    !rd_in ##1 1'b1;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  copy_gate_a: assert property (copy_allow_out |-> copy_req_in)
    else $error("copy allowed without request");
  lock_count_a: assert property
    (keypad_locked_out == (bad_count_out == dpm_pkg::MAX_BAD_TRIES))
    else $error("lock level disagrees with count");
  flash_lock_a: assert property (lock_flash_out |-> keypad_locked_out)
    else $error("flash without lock");
  count_step_a: assert property ((bad_count_out > $past(bad_count_out))
    |-> bad_count_out == $past(bad_count_out) + 3'h1)
    else $error("wrong entry count jumped");
  count_cap_a: assert property (bad_count_out <= 3'h4)
    else $error("wrong entry count above four");
  reset_pulse_a: assert property (factory_reset_out |-> s_pulse)
    else $error("restore pulse longer than one cycle");
  overload_low_a: assert property ((overload_in < dpm_pkg::OVERLOAD_LIMIT)
    |-> !overload_warning_out)
    else $error("overload warning below limit");
  torque_fmt_a: assert property
    (torque_mode_out |-> speed_format_out == '0)
    else $error("speed format shown in torque mode");
  mode_cause_a: assert property ($changed(torque_mode_out)
    |-> $past(wr_in && addr_in == dpm_pkg::ADDR_CTRL_MODE)
        || $past(factory_reset_out))
    else $error("mode changed without write");
  idle_data_a: assert property (s_no_read |-> rdata_out == '0)
    else $error("read data outside read slot");
endmodule

/* File: sim/dpm_master_model.sv */
`timescale 1ns/1ps
// Remote master and keypad: one-cycle strobes after a rising edge
module dpm_master_model (
  input  wire logic        clk_in,
  output logic      [15:0] addr_out,
  output logic      [15:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic             keypad_out
);
  initial {addr_out, wdata_out, wr_out, rd_out, keypad_out} = '0;

  // Write cycle; a gap edge follows so strobes never double up
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic k);
    @(posedge clk_in);
    addr_out   <= a;
    wdata_out  <= d;
    keypad_out <= k;
    wr_out     <= 1'b1;
    @(posedge clk_in);
    wr_out     <= 1'b0;
    wdata_out  <= ~d; // Stale data must not be trusted
  endtask

  // Read cycle; data lands in the next cycle
  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
  endtask

  // Operator clears a forgotten password: code twice, well inside window
  task automatic clear_code(input logic k);
    wr(dpm_pkg::ADDR_PW_ENTRY, dpm_pkg::PW_RESET_CODE, k);
    wr(dpm_pkg::ADDR_PW_ENTRY, dpm_pkg::PW_RESET_CODE, k);
  endtask
endmodule

/* File: sim/drive_param_protect_monitor_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t got %h want %h", $time, a, e); \
  end end
module drive_param_protect_monitor_bench;
  localparam logic [15:0] FW = 16'h00A5; // Arbitrary value
  localparam int WIN = 100; // Short restore window keeps the run brief
  logic        clk = 0, rstn = 0, rd_q = 0, fres_seen = 0;
  logic [15:0] addr, wdata, rdata, freq = '0, torq = '0, ovl = '0, sfmt;
  logic        wr, rd, kp, fwd = 0, rev = 0, rdy = 0, err = 0, warn = 0;
  logic [6:0]  din = '0;
  logic [2:0]  dout = '0, bcnt;
  logic        creq = 0, callow, locked, flash, fres, owarn, tmode, irq;
  logic [15:0] expq[$], exp_v;
  int          mismatches = 0, comparisons = 0;

  always #20 clk = ~clk;

  dpm_param_bank #(.FW_VERSION(FW), .RESET_WINDOW(WIN)) i_dpm_param_bank (
    .core_clk_in(clk), .resetn_in(rstn), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .keypad_src_in(kp), .rdata_out(rdata),
    .din_pin_in(din), .dout_state_in(dout), .run_fwd_in(fwd),
    .run_rev_in(rev), .drive_ready_in(rdy), .drive_error_in(err),
    .ext_warning_in(warn), .out_freq_in(freq), .torque_in(torq),
    .overload_in(ovl), .copy_req_in(creq), .copy_allow_out(callow),
    .keypad_locked_out(locked), .lock_flash_out(flash),
    .bad_count_out(bcnt), .factory_reset_out(fres),
    .overload_warning_out(owarn), .torque_mode_out(tmode),
    .speed_format_out(sfmt), .irq_out(irq));

  dpm_master_model i_dpm_master_model (.clk_in(clk), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .keypad_out(kp));

  // ----------------------------------------------------------------
  // Result watcher: read data is only valid in the slot after rd
  // ----------------------------------------------------------------
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (fres) fres_seen = 1'b1;
    if (rd_q) begin
      // Pop once: the macro names its expected value twice
      exp_v = expq.pop_front();
      `CHK(rdata, exp_v)
    end
  end

  task automatic w(input logic [15:0] a, d);
    i_dpm_master_model.wr(a, d, 1'b0);
  endtask
  task automatic rdc(input logic [15:0] a, e);
    expq.push_back(e);
    i_dpm_master_model.rd(a);
  endtask
  task automatic show(input logic [15:0] s, e);
    w(dpm_pkg::ADDR_DISPLAY_SEL, s);
    rdc(dpm_pkg::ADDR_DISPLAY_VAL, e);
  endtask

  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, generous against roughly 240 cycles of traffic
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    void'($urandom(84364));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    din  <= 7'($urandom);
    dout <= 3'($urandom);
    rdc(dpm_pkg::ADDR_FW_VERSION, FW);
    w(dpm_pkg::ADDR_FW_VERSION, 16'hFFFF);
    rdc(dpm_pkg::ADDR_FW_VERSION, FW);
    rdc(dpm_pkg::ADDR_COEF_GAIN, dpm_pkg::COEF_GAIN_RESET);
    rdc(dpm_pkg::ADDR_PW_ENTRY, 16'h0000);
    rdc(dpm_pkg::ADDR_PW_SETTING, 16'h0000);
    rdc(16'h0200, 16'h0000);
    // Monitor words, plain, inverted and run-wire exempted inputs
    show(dpm_pkg::SEL_DI_ADJ, {9'h0, din});
    show(dpm_pkg::SEL_DO_RAW, {13'h0, dout});
    w(dpm_pkg::ADDR_IN_POLARITY, 16'h007F);
    w(dpm_pkg::ADDR_OUT_POLARITY, 16'h0007);
    show(dpm_pkg::SEL_DI_ADJ, {9'h0, ~din});
    show(dpm_pkg::SEL_DI_RAW, {9'h0, din});
    show(dpm_pkg::SEL_DO_ADJ, {13'h0, ~dout});
    w(dpm_pkg::ADDR_RUN_WIRE_SEL, 16'h0001);
    show(dpm_pkg::SEL_DI_ADJ, {9'h0, ~din[6:3], din[2:0]});
    {fwd, rdy, err, warn} <= 4'hF;
    show(dpm_pkg::SEL_STATUS, 16'h003D);
    freq <= 16'd500;
    w(dpm_pkg::ADDR_COEF_GAIN, 16'd250);
    show(dpm_pkg::SEL_GAIN_FREQ, 16'd1250);
    w(dpm_pkg::ADDR_COEF_GAIN, 16'd16500);
    rdc(dpm_pkg::ADDR_COEF_GAIN, dpm_pkg::COEF_GAIN_MAX);
    // Overload warning, unmasked, raises and clears the interrupt
    w(dpm_pkg::ADDR_INT_MASK, 16'h0004);
    w(dpm_pkg::ADDR_DISPLAY_SEL, dpm_pkg::SEL_OVERLOAD);
    ovl <= 16'd9999;
    repeat (2) @(negedge clk);
    `CHK({owarn, irq}, 2'b00)
    @(posedge clk);
    ovl <= dpm_pkg::OVERLOAD_LIMIT;
    repeat (2) @(negedge clk);
    `CHK({owarn, irq}, 2'b11)
    rdc(dpm_pkg::ADDR_INT_STATUS, 16'h0004);
    ovl <= '0;
    w(dpm_pkg::ADDR_INT_STATUS, 16'h0004);
    @(negedge clk);
    `CHK(irq, 1'b0)
    // Control modes; an undefined code leaves torque mode in place
    w(dpm_pkg::ADDR_SPEED_FORMAT, 16'h0005);
    w(dpm_pkg::ADDR_CTRL_MODE, dpm_pkg::MODE_TORQUE);
    w(dpm_pkg::ADDR_CTRL_MODE, 16'h0001);
    @(negedge clk);
    `CHK({tmode, sfmt}, 17'h10000)
    w(dpm_pkg::ADDR_CTRL_MODE, dpm_pkg::MODE_SPEED);
    @(negedge clk);
    `CHK({tmode, sfmt}, 17'h00005)
    // Protection, wrong entries from the keypad up to lockout
    w(dpm_pkg::ADDR_PW_SETTING, 16'd1234);
    creq <= 1'b1;
    rdc(dpm_pkg::ADDR_PW_SETTING, dpm_pkg::PW_SET_ACTIVE);
    rdc(dpm_pkg::ADDR_COEF_GAIN, 16'h0000);
    `CHK(callow, 1'b0)
    for (int i = 1; i <= 4; i++) begin
      i_dpm_master_model.wr(dpm_pkg::ADDR_PW_ENTRY, 16'd1000 + 16'(i), 1);
      @(negedge clk);
      `CHK({locked, bcnt}, {i == 4, 3'(i)})
    end
    `CHK({locked, flash}, 2'b10)
    i_dpm_master_model.wr(dpm_pkg::ADDR_PW_ENTRY, 16'd1234, 1'b1);
    rdc(dpm_pkg::ADDR_PW_SETTING, dpm_pkg::PW_SET_ACTIVE);
    w(dpm_pkg::ADDR_PW_ENTRY, 16'd1234);
    rdc(dpm_pkg::ADDR_PW_SETTING, 16'h0000);
    rdc(dpm_pkg::ADDR_COEF_GAIN, dpm_pkg::COEF_GAIN_MAX);
    `CHK(callow, 1'b1)
    // Clearing code twice inside the window restores defaults
    i_dpm_master_model.clear_code(1'b0);
    @(negedge clk);
    `CHK(fres_seen, 1'b1)
    rdc(dpm_pkg::ADDR_COEF_GAIN, dpm_pkg::COEF_GAIN_RESET);
    // A second code after the window has lapsed only re-arms it
    fres_seen = 1'b0;
    w(dpm_pkg::ADDR_PW_ENTRY, dpm_pkg::PW_RESET_CODE);
    repeat (WIN + 10) @(posedge clk);
    w(dpm_pkg::ADDR_PW_ENTRY, dpm_pkg::PW_RESET_CODE);
    @(negedge clk);
    `CHK(fres_seen, 1'b0)
    repeat (3) @(posedge clk);
    `CHK(expq.size(), 0)
    conclude();
  end
endmodule

bind dpm_param_bank dpm_chk i_dpm_chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wr_in(wr_in), .rd_in(rd_in), .copy_req_in(copy_req_in),
  .overload_in(overload_in), .rdata_out(rdata_out),
  .copy_allow_out(copy_allow_out), .keypad_locked_out(keypad_locked_out),
  .lock_flash_out(lock_flash_out), .bad_count_out(bad_count_out),
  .factory_reset_out(factory_reset_out),
  .overload_warning_out(overload_warning_out),
  .torque_mode_out(torque_mode_out), .speed_format_out(speed_format_out));
